// [hdl/serial_host_pkg.sv]
package serial_host_pkg;

  // Register byte offsets
  localparam logic [7:0]  CSR_OFF   = 8'h00;
  localparam logic [7:0]  CKR_OFF   = 8'h04;
  localparam logic [7:0]  TXD_OFF   = 8'h08;
  localparam logic [7:0]  RXD_OFF   = 8'h0C;

  // Status bit positions in the control/status register
  localparam int          TUE_BIT   = 14;
  localparam int          TDE_BIT   = 15;
  localparam int          RNE_BIT   = 17;
  localparam int          RFF_BIT   = 19;
  localparam int          ROE_BIT   = 20;
  localparam int          BER_BIT   = 21;
  localparam int          BUSY_BIT  = 22;

  // Reset values and writable masks
  localparam logic [8:0]  CTRL_RST  = 9'h000;
  localparam logic [13:0] CKR_RST   = 14'h0001;
  localparam logic [13:0] CKR_MASK  = 14'h37FF;
  localparam logic [7:0]  PINS_RST  = 8'h02;

  // Word size codes and lengths
  localparam logic [1:0]  WS_8      = 2'h0;
  localparam logic [1:0]  WS_16     = 2'h1;
  localparam logic [1:0]  WS_24     = 2'h2;
  localparam logic [1:0]  WS_RSV    = 2'h3;
  localparam logic [4:0]  LEN_8     = 5'h08;
  localparam logic [4:0]  LEN_16    = 5'h10;
  localparam logic [4:0]  LEN_24    = 5'h18;

  // Receive FIFO levels and fixed prescaler (divide by eight)
  localparam logic [3:0]  RX_LEVELS = 4'hA;
  localparam logic [2:0]  PRE_LAST  = 3'h7;

  typedef struct packed {
    logic [1:0] rq_mode;
    logic       master;
    logic       depth;
    logic       stretch;
    logic [1:0] word_size;
    logic       i2c;
    logic       enable;
  } ctrl_s;

  typedef struct packed {
    logic [1:0] fm;
    logic       rsv;
    logic [7:0] dm;
    logic       hrs;
    logic       cpol;
    logic       cpha;
  } clk_s;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic req_o;
    logic req_oe;
  } pins_s;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_SHIFT, ST_STOP} eng_e;

endpackage : serial_host_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels in and synchronised levels out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule : pin_sync

// [hdl/serial_host_ctrl.sv]
`timescale 1ns/10ps
module serial_host_ctrl #(
  parameter logic [3:0] RX_DEPTH = serial_host_pkg::RX_LEVELS
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Serial clock (SCK or SCL)
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE,
  // MOSI, also SDA in I2C
  input  wire logic        MOSI_I,
  output logic             MOSI_O,
  output logic             MOSI_OE,
  // MISO
  input  wire logic        MISO_I,
  output logic             MISO_O,
  output logic             MISO_OE,
  // Slave select and host request
  input  wire logic        SS_N_I,
  input  wire logic        HOST_REQUEST_PIN_N_I,
  output logic             HOST_REQUEST_PIN_N_O,
  output logic             HOST_REQUEST_PIN_N_OE
);

  serial_host_pkg::ctrl_s ctrl_reg;
  serial_host_pkg::ctrl_s ctrl_wr;
  serial_host_pkg::clk_s  ckr_reg;
  serial_host_pkg::pins_s pins_reg;
  serial_host_pkg::pins_s pins_next;
  serial_host_pkg::eng_e  st_reg;
  logic        en_d_reg;
  logic [23:0] txh_reg;
  logic [23:0] sh_reg;
  logic        tde_reg;
  logic        tue_reg;
  logic        tue_rd_reg;
  logic        roe_reg;
  logic        ber_reg;
  logic [4:0]  bits_left_reg;
  logic        ph_reg;
  logic        ack_reg;
  logic        cap_reg;
  logic        dout_reg;
  logic        sck_reg;
  logic        sda_reg;
  logic        stretch_reg;
  logic        frame_reg;
  logic [2:0]  pre_reg;
  logic [7:0]  div_reg;
  logic [23:0] rx_mem [0:RX_DEPTH-1];
  logic [3:0]  wp_reg;
  logic [3:0]  rp_reg;
  logic [3:0]  cnt_reg;
  logic        rd_ne_reg;
  logic [31:0] prdata_reg;
  logic [4:0]  s_in;
  logic        sck_q_reg;
  logic        sda_q_reg;

  function automatic logic [4:0] wlen(input logic [1:0] ws);
    case (ws)
      serial_host_pkg::WS_16: wlen = serial_host_pkg::LEN_16;
      serial_host_pkg::WS_24: wlen = serial_host_pkg::LEN_24;
      default:                wlen = serial_host_pkg::LEN_8;
    endcase
  endfunction : wlen

  function automatic logic [23:0] ljust(input logic [23:0] v, input logic [1:0] ws);
    case (ws)
      serial_host_pkg::WS_16: ljust = {v[15:0], 8'h00};
      serial_host_pkg::WS_24: ljust = v;
      default:                ljust = {v[7:0], 16'h0000};
    endcase
  endfunction : ljust

  function automatic logic [23:0] rjust(input logic [23:0] v, input logic [1:0] ws);
    case (ws)
      serial_host_pkg::WS_16: rjust = {8'h00, v[15:0]};
      serial_host_pkg::WS_24: rjust = v;
      default:                rjust = {16'h0000, v[7:0]};
    endcase
  endfunction : rjust

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p == RX_DEPTH - 4'h1) ? 4'h0 : p + 4'h1;
  endfunction : ptr_inc

  // APB decode: zero wait states, read data latched in the setup cycle
  wire logic apb_set = PSEL & ~PENABLE;
  wire logic apb_acc = PSEL & PENABLE;
  wire logic wr      = apb_acc & PWRITE;
  wire logic rd      = apb_acc & ~PWRITE;
  wire logic hit_csr = PADDR == serial_host_pkg::CSR_OFF;
  wire logic hit_ckr = PADDR == serial_host_pkg::CKR_OFF;
  wire logic hit_txd = PADDR == serial_host_pkg::TXD_OFF;
  wire logic hit_rxd = PADDR == serial_host_pkg::RXD_OFF;
  wire logic mapped  = hit_csr | hit_ckr | hit_txd | hit_rxd;
  wire logic wr_csr  = wr & hit_csr;
  wire logic wr_ckr  = wr & hit_ckr;
  wire logic wr_txd  = wr & hit_txd;
  wire logic ber_clr = wr_csr & PWDATA[serial_host_pkg::BER_BIT];

  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc & ~mapped;
  assign PRDATA  = prdata_reg;

  wire logic [1:0] ws_in   = PWDATA[3:2];
  wire logic       ws_rsv  = ws_in == serial_host_pkg::WS_RSV;
  wire logic [1:0] ws_keep = ws_rsv ? ctrl_reg.word_size : ws_in;
  assign ctrl_wr = {PWDATA[8:4], ws_keep, PWDATA[1:0]};

  // Control bits answer only to the chip resets, never to the unit enable
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      ctrl_reg <= serial_host_pkg::CTRL_RST;
      ckr_reg  <= serial_host_pkg::CKR_RST;
    end
    else
    begin
      if (wr_csr)
        ctrl_reg <= ctrl_wr;
      if (wr_ckr)
        ckr_reg <= PWDATA[13:0] & serial_host_pkg::CKR_MASK;
    end
  end

  // Enable acts one cycle after it is written
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      en_d_reg <= 1'b0;
    else
      en_d_reg <= ctrl_reg.enable;
  end

  wire logic ind_rst = SRST | ~en_d_reg;

  pin_sync #(
    .W       (5),
    .RST_VAL (5'h1F)
  ) u_sync (
    .clk  (MCLK),
    .rst  (SRST),
    .din  ({SCK_I, MOSI_I, MISO_I, SS_N_I, HOST_REQUEST_PIN_N_I}),
    .dout (s_in)
  );

  // Inputs read high while the unit is held in reset
  wire logic s_sck   = s_in[4] | ~en_d_reg;
  wire logic s_sda   = s_in[3] | ~en_d_reg;
  wire logic s_miso  = s_in[2] | ~en_d_reg;
  wire logic s_ss_n  = s_in[1] | ~en_d_reg;
  wire logic s_req_n = s_in[0] | ~en_d_reg;

  always_ff @(posedge MCLK)
  begin
    sck_q_reg <= s_sck;
    sda_q_reg <= s_sda;
  end

  wire logic rise     = s_sck & ~sck_q_reg;
  wire logic fall     = ~s_sck & sck_q_reg;
  wire logic i2c_strt = s_sck & sck_q_reg & ~s_sda & sda_q_reg;
  wire logic i2c_stop = s_sck & sck_q_reg & s_sda & ~sda_q_reg;

  wire logic i2c      = ctrl_reg.i2c;
  wire logic mst      = ctrl_reg.master;
  wire logic spi_m    = ~i2c & mst;
  wire logic spi_s    = ~i2c & ~mst;
  wire logic i2c_m    = i2c & mst;
  wire logic i2c_s    = i2c & ~mst;
  wire logic busy     = st_reg != serial_host_pkg::ST_IDLE;
  wire logic shifting = st_reg == serial_host_pkg::ST_SHIFT;

  wire logic [3:0] lim  = ctrl_reg.depth ? RX_DEPTH : 4'h1;
  wire logic       full = cnt_reg == lim;
  wire logic       rne  = cnt_reg != 4'h0;

  // Clock generator: optional divide by eight, then divide by dm + 1
  wire logic pre_tick = ckr_reg.hrs | (pre_reg == serial_host_pkg::PRE_LAST);
  wire logic tick     = pre_tick & (div_reg == ckr_reg.dm);
  wire logic hold     = mst & (ctrl_reg.rq_mode != 2'h0) & s_req_n;
  wire logic m_tick   = tick & ~hold;

  always_ff @(posedge MCLK)
  begin
    if (ind_rst)
    begin
      pre_reg <= 3'h0;
      div_reg <= 8'h00;
    end
    else
    begin
      pre_reg <= pre_tick ? 3'h0 : pre_reg + 3'h1;
      if (pre_tick)
        div_reg <= tick ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Shift engine timing: lead and trail edges of each bit
  wire logic cpha  = ~i2c & ckr_reg.cpha;
  wire logic cpol  = ~i2c & ckr_reg.cpol;
  wire logic lead  = shifting & (mst ? m_tick & ~ph_reg : (cpol ? fall : rise));
  wire logic trail = shifting & (mst ? m_tick & ph_reg : (cpol ? rise : fall));
  wire logic din   = spi_m ? s_miso : s_sda;
  wire logic last  = bits_left_reg == 5'h01;
  wire logic b_end = i2c & (bits_left_reg[2:0] == 3'h1);
  wire logic bit_in = cpha ? din : cap_reg;
  wire logic [23:0] sh_shift = {sh_reg[22:0], bit_in};
  wire logic finish = trail & (ack_reg ? bits_left_reg == 5'h00 : last & ~i2c);
  wire logic [23:0] rx_word = rjust(ack_reg ? sh_reg : sh_shift, ctrl_reg.word_size);
  wire logic [23:0] tx_just = ljust(txh_reg, ctrl_reg.word_size);

  // Start of a word for either role
  wire logic s_ready    = ~tde_reg & ~full;
  wire logic stretch_on = i2c_s & ctrl_reg.stretch;
  wire logic unready    = stretch_on & ~s_ready;
  wire logic i2c_s_go   = i2c_s & frame_reg & ~s_sck & ~unready;
  wire logic sl_go      = ~busy & en_d_reg & ((spi_s & ~s_ss_n) | i2c_s_go);
  wire logic m_go       = ~busy & en_d_reg & mst & ~tde_reg;
  wire logic load       = sl_go | m_go;
  wire logic underrun   = sl_go & tde_reg;
  wire logic abort      = shifting & ((spi_s & s_ss_n) | (i2c_s & i2c_stop));
  wire logic tde_set    = (load & ~(spi_m & ~cpha)) | (finish & spi_m & ~cpha);

  // Sequencer: start, bits, acknowledge, stop
  always_ff @(posedge MCLK)
  begin
    if (ind_rst)
    begin
      st_reg  <= serial_host_pkg::ST_IDLE;
      ph_reg  <= 1'b0;
      sck_reg <= 1'b0;
      sda_reg <= 1'b1;
    end
    else if (abort)
      st_reg <= serial_host_pkg::ST_IDLE;
    else
    begin
      case (st_reg)
        serial_host_pkg::ST_IDLE:
          if (load)
          begin
            st_reg  <= i2c_m ? serial_host_pkg::ST_START : serial_host_pkg::ST_SHIFT;
            ph_reg  <= 1'b0;
            sck_reg <= i2c_m;
            sda_reg <= ~i2c_m;
          end
        serial_host_pkg::ST_START:
          if (m_tick)
          begin
            st_reg  <= serial_host_pkg::ST_SHIFT;
            sck_reg <= 1'b0;
          end
        serial_host_pkg::ST_SHIFT:
        begin
          if (mst & m_tick)
          begin
            ph_reg  <= ~ph_reg;
            sck_reg <= ~ph_reg;
          end
          if (finish)
          begin
            st_reg  <= i2c_m ? serial_host_pkg::ST_STOP : serial_host_pkg::ST_IDLE;
            ph_reg  <= 1'b0;
            sda_reg <= ~i2c_m;
          end
        end
        serial_host_pkg::ST_STOP:
          if (m_tick)
          begin
            ph_reg <= 1'b1;
            if (ph_reg)
            begin
              sda_reg <= 1'b1;
              st_reg  <= serial_host_pkg::ST_IDLE;
            end
            else
              sck_reg <= 1'b1;
          end
        default:
          st_reg <= serial_host_pkg::ST_IDLE;
      endcase
    end
  end

  // Data path of the shift register
  always_ff @(posedge MCLK)
  begin
    if (ind_rst)
    begin
      sh_reg        <= 24'h000000;
      bits_left_reg <= 5'h00;
      ack_reg       <= 1'b0;
      cap_reg       <= 1'b0;
      dout_reg      <= 1'b1;
    end
    else if (load)
    begin
      sh_reg        <= tx_just;
      bits_left_reg <= wlen(ctrl_reg.word_size);
      ack_reg       <= 1'b0;
      dout_reg      <= tx_just[23];
    end
    else if (lead & ~ack_reg)
    begin
      if (cpha)
        dout_reg <= sh_reg[23];
      else
        cap_reg <= din;
    end
    else if (trail & ack_reg)
      ack_reg <= 1'b0;
    else if (trail)
    begin
      sh_reg        <= sh_shift;
      bits_left_reg <= bits_left_reg - 5'h01;
      ack_reg       <= b_end;
      if (~cpha)
        dout_reg <= sh_reg[22];
    end
  end

  // Status flags: hardware set wins over software clear
  always_ff @(posedge MCLK)
  begin
    if (ind_rst)
    begin
      txh_reg    <= 24'h000000;
      tde_reg    <= 1'b1;
      tue_reg    <= 1'b0;
      tue_rd_reg <= 1'b0;
      roe_reg    <= 1'b0;
      ber_reg    <= 1'b0;
      frame_reg  <= 1'b0;
    end
    else
    begin
      if (wr_txd)
        txh_reg <= PWDATA[23:0];
      tde_reg    <= tde_set | (tde_reg & ~wr_txd);
      tue_rd_reg <= (rd & hit_csr) | (tue_rd_reg & ~wr_txd);
      tue_reg    <= underrun | (tue_reg & ~(wr_txd & tue_rd_reg));
      roe_reg    <= (finish & full) | (roe_reg & ~(rd & hit_rxd));
      ber_reg    <= (spi_m & ~s_ss_n) | (ber_reg & ~ber_clr);
      frame_reg  <= i2c_s & (i2c_strt | (frame_reg & ~i2c_stop));
    end
  end

  // Clock stretch holds SCL low until the slave can serve the master
  always_ff @(posedge MCLK)
  begin
    if (ind_rst)
      stretch_reg <= 1'b0;
    else
      stretch_reg <= frame_reg & ~busy & unready & (~s_sck | stretch_reg);
  end

  // Receive FIFO
  wire logic wr_ok = finish & ~full;
  wire logic pop   = rd & hit_rxd & rd_ne_reg;

  always_ff @(posedge MCLK)
  begin
    if (ind_rst)
    begin
      wp_reg  <= 4'h0;
      rp_reg  <= 4'h0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      if (wr_ok)
        wp_reg <= ptr_inc(wp_reg);
      if (pop)
        rp_reg <= ptr_inc(rp_reg);
      cnt_reg <= cnt_reg + {3'h0, wr_ok} - {3'h0, pop};
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (wr_ok)
      rx_mem[wp_reg] <= rx_word;
  end

  // Register read data
  wire logic [31:0] csr_val = {9'h000, busy, ber_reg, roe_reg, full, 1'b0, rne, 1'b0,
                               tde_reg, tue_reg, 5'h00, ctrl_reg};
  wire logic [31:0] rd_val  = hit_csr ? csr_val :
                              hit_ckr ? {18'h00000, ckr_reg} :
                              hit_rxd ? {8'h00, rx_mem[rp_reg]} : 32'h00000000;

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      prdata_reg <= 32'h00000000;
      rd_ne_reg  <= 1'b0;
    end
    else if (apb_set)
    begin
      prdata_reg <= rd_val;
      rd_ne_reg  <= rne;
    end
  end

  // Pins
  wire logic sda_m  = shifting ? (ack_reg | dout_reg) : sda_reg;
  wire logic tx_rdy = ~tde_reg;
  wire logic rx_rdy = ~full;
  wire logic both   = i2c ? (tx_rdy | rx_rdy) : (tx_rdy & rx_rdy);
  wire logic req_act = (ctrl_reg.rq_mode == 2'h1) ? rx_rdy :
                       (ctrl_reg.rq_mode == 2'h2) ? tx_rdy : both;

  always_comb
  begin
    pins_next = serial_host_pkg::PINS_RST;
    if (en_d_reg)
    begin
      pins_next.req_oe = ~mst & (ctrl_reg.rq_mode != 2'h0);
      pins_next.req_o  = ~req_act;
      if (spi_m)
      begin
        pins_next.sck_o   = sck_reg ^ cpol;
        pins_next.sck_oe  = 1'b1;
        pins_next.mosi_o  = dout_reg;
        pins_next.mosi_oe = 1'b1;
      end
      else if (spi_s)
      begin
        pins_next.miso_o  = dout_reg;
        pins_next.miso_oe = ~s_ss_n;
      end
      else if (i2c_m)
      begin
        pins_next.sck_oe  = busy & ~sck_reg;
        pins_next.mosi_oe = ~sda_m;
      end
      else
      begin
        pins_next.sck_oe  = stretch_reg;
        pins_next.mosi_oe = shifting & (ack_reg | ~dout_reg);
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
      pins_reg <= serial_host_pkg::PINS_RST;
    else
      pins_reg <= pins_next;
  end

  assign SCK_O     = pins_reg.sck_o;
  assign SCK_OE    = pins_reg.sck_oe;
  assign MOSI_O    = pins_reg.mosi_o;
  assign MOSI_OE   = pins_reg.mosi_oe;
  assign MISO_O    = pins_reg.miso_o;
  assign MISO_OE   = pins_reg.miso_oe;
  assign HOST_REQUEST_PIN_N_O  = pins_reg.req_o;
  assign HOST_REQUEST_PIN_N_OE = pins_reg.req_oe;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  AST_EN_DELAY: assert property ($fell(ctrl_reg.enable) |-> en_d_reg ##1 !en_d_reg)
    else $error("unit reset not one cycle after disable");
  AST_CTRL_KEEP: assert property ($fell(en_d_reg) && !$past(wr_ckr)
    |-> $stable(ckr_reg))
    else $error("clock control changed by disable");
  AST_RESET_CLR: assert property (disable iff (1'b0) SRST |=> ctrl_reg == 9'h000)
    else $error("control bits not cleared by reset");
  AST_FLOAT: assert property (!en_d_reg |=>
    !SCK_OE && !MOSI_OE && !MISO_OE && !HOST_REQUEST_PIN_N_OE)
    else $error("pin driven during unit reset");
  AST_WS_RSV: assert property (wr_csr && PWDATA[3:2] == 2'h3 |=>
    ctrl_reg.word_size == $past(ctrl_reg.word_size))
    else $error("reserved word size stored");
  AST_WLEN: assert property (load |=>
    bits_left_reg == {$past(ctrl_reg.word_size) + 2'h1, 3'h0})
    else $error("word length does not match size code");
  AST_REQ_Z: assert property (ctrl_reg.rq_mode == 2'h0 |=> !HOST_REQUEST_PIN_N_OE)
    else $error("request pin driven in mode zero");
  AST_BER: assert property (en_d_reg && spi_m && !s_ss_n |=> ber_reg)
    else $error("bus error not flagged");
  AST_SUSPEND: assert property (hold [*3] |-> $stable(SCK_O))
    else $error("clock moved while suspended");
  AST_STRETCH: assert property (!mst && !stretch_on |=> ##1 !SCK_OE)
    else $error("stretch outside I2C slave");
  AST_OVR: assert property (finish && full |=> roe_reg)
    else $error("overrun not flagged");

  COV_SPI_WORD: cover property (spi_m && finish);
  COV_I2C_STOP: cover property (st_reg == serial_host_pkg::ST_STOP ##[1:1000] !busy);
  COV_STRETCH: cover property (stretch_reg && SCK_OE);
  COV_FIFO_FULL: cover property (ctrl_reg.depth && full);

endmodule : serial_host_ctrl

// [tb/spi_far_slave.sv]
`timescale 1ns/10ps
module spi_far_slave (
  // Serial lines
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Word to send, its load strobe and word received
  input  wire logic       load,
  input  wire logic [7:0] tx_word,
  output logic [7:0]      rx_word
);
  logic [7:0] sh_reg;

  initial
  begin
    miso = 1'b1;
    sh_reg = 8'h00;
  end
  assign rx_word = sh_reg;
  always @(posedge load) sh_reg <= tx_word;
  // Shift out on the leading edge, sample on the trailing edge, MSB first
  always @(posedge sck) miso <= sh_reg[7];
  always @(negedge sck) sh_reg <= {sh_reg[6:0], mosi};
endmodule : spi_far_slave

// [tb/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {logic [7:0] a; logic [31:0] wd; logic [31:0] ex;} row_s;
  logic        MCLK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        PREADY, PSLVERR, SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE;
  logic        SS_N_I = 1'b1, HOST_REQUEST_PIN_N_I = 1'b1, HOST_REQUEST_PIN_N_O, HOST_REQUEST_PIN_N_OE, err;
  logic        far_miso, load = 1'b0, sck_w, mosi_w;
  logic [7:0]  far_tx = 8'h00, far_rx;
  int          cycles = 0, miscompares = 0, n_tests = 0, n_sck = 0;
  row_s        rows [5] = '{'{8'h00, 32'h00000006, 32'h00008006},
                            '{8'h00, 32'h0000000C, 32'h00008004},
                            '{8'h00, 32'h000001F8, 32'h000081F8},
                            '{8'h00, 32'hFFFFFE00, 32'h00008000},
                            '{8'h04, 32'h0000FFFF, 32'h000037FF}};

  assign sck_w  = SCK_OE ? SCK_O : 1'b0;
  assign mosi_w = MOSI_OE ? MOSI_O : 1'b1;
  always #50 MCLK = ~MCLK;
  always @(posedge sck_w) n_sck++;
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  serial_host_ctrl dut (.MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .MOSI_I(mosi_w),
    .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE), .MISO_I(MISO_OE ? MISO_O : far_miso),
    .MISO_O(MISO_O), .MISO_OE(MISO_OE), .SS_N_I(SS_N_I), .HOST_REQUEST_PIN_N_I(HOST_REQUEST_PIN_N_I),
    .HOST_REQUEST_PIN_N_O(HOST_REQUEST_PIN_N_O), .HOST_REQUEST_PIN_N_OE(HOST_REQUEST_PIN_N_OE));
  spi_far_slave far (.sck(sck_w), .mosi(mosi_w), .miso(far_miso), .load(load),
    .tx_word(far_tx), .rx_word(far_rx));

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge MCLK);
    end
    while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask : rdchk

  task automatic wcyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask : wcyc

  task automatic poll_idle;
    do
    begin
      apb(1'b0, serial_host_pkg::CSR_OFF, 32'h0);
    end
    while (rd[serial_host_pkg::BUSY_BIT] !== 1'b0);
  endtask : poll_idle

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    wcyc(3);
    SRST <= 1'b0;
    rdchk("csr reset", 8'h00, 32'h00008000);
    rdchk("ckr reset", 8'h04, 32'h00000001);
    rdchk("unmapped", 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("pins float", 32'h0, {28'h0, SCK_OE, MOSI_OE, MISO_OE, HOST_REQUEST_PIN_N_OE});
    $display("test reset done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].wd);
      rdchk("register row", rows[i].a, rows[i].ex);
    end
    $display("test register rows done");
    // Bit time of eight clocks leaves room for the input synchroniser
    apb(1'b1, 8'h04, 32'h0000001D);
    apb(1'b1, 8'h00, 32'h00000041);
    far_tx = 8'h3C;
    load = 1'b1;
    apb(1'b1, 8'h08, 32'h000000A5);
    wcyc(1);
    chk("sck driven", 32'h1, {31'h0, SCK_OE});
    poll_idle();
    chk("far side got", 32'h000000A5, {24'h0, far_rx});
    rdchk("rx word", 8'h0C, 32'h0000003C);
    load = 1'b0;
    $display("test spi master done");
    SS_N_I <= 1'b0;
    wcyc(5);
    SS_N_I <= 1'b1;
    rdchk("bus error set", 8'h00, 32'h00208041);
    apb(1'b1, 8'h00, 32'h00200041);
    rdchk("bus error clear", 8'h00, 32'h00008041);
    $display("test bus error done");
    apb(1'b1, 8'h00, 32'h000000C1);
    far_tx = 8'h5A;
    load = 1'b1;
    n_sck = 0;
    apb(1'b1, 8'h08, 32'h000000FF);
    wcyc(40);
    chk("suspended edges", 32'h0, n_sck);
    rdchk("suspended busy", 8'h00, 32'h004080C1);
    HOST_REQUEST_PIN_N_I <= 1'b0;
    poll_idle();
    rdchk("resumed rx", 8'h0C, 32'h0000005A);
    $display("test request suspend done");
    apb(1'b1, 8'h08, 32'h00000081);
    apb(1'b1, 8'h08, 32'h00000042);
    wcyc(200);
    rdchk("overrun", 8'h00, 32'h001A80C1);
    $display("test overrun done");
    apb(1'b1, 8'h00, 32'h000000C0);
    wcyc(3);
    chk("disabled float", 32'h0, {28'h0, SCK_OE, MOSI_OE, MISO_OE, HOST_REQUEST_PIN_N_OE});
    rdchk("bits kept", 8'h00, 32'h000080C0);
    $display("test disable done");
    apb(1'b1, 8'h00, 32'h00000101);
    wcyc(3);
    chk("req tx empty", 32'h3, {30'h0, HOST_REQUEST_PIN_N_OE, HOST_REQUEST_PIN_N_O});
    apb(1'b1, 8'h00, 32'h00000181);
    wcyc(3);
    chk("req both empty", 32'h3, {30'h0, HOST_REQUEST_PIN_N_OE, HOST_REQUEST_PIN_N_O});
    apb(1'b1, 8'h08, 32'h00000011);
    wcyc(3);
    chk("req tx ready", 32'h2, {30'h0, HOST_REQUEST_PIN_N_OE, HOST_REQUEST_PIN_N_O});
    apb(1'b1, 8'h00, 32'h00000081);
    wcyc(3);
    chk("req rx ready", 32'h2, {30'h0, HOST_REQUEST_PIN_N_OE, HOST_REQUEST_PIN_N_O});
    apb(1'b1, 8'h00, 32'h00000001);
    wcyc(3);
    chk("req float", 32'h0, {31'h0, HOST_REQUEST_PIN_N_OE});
    $display("test request pin done");
    SRST <= 1'b1;
    wcyc(3);
    SRST <= 1'b0;
    rdchk("csr rereset", 8'h00, 32'h00008000);
    $display("test mid reset done");
    give_verdict();
  end
endmodule : tb_top
